// [hdl/ssor_routing.sv]
// servo status generation and routing to connector output terminals
// assumes: status conditions come from drive logic on sys_clk_in, except
// main power and hardware base block which arrive as pins; parameters
// come from the parameter store on the same clock
// assumes the host reads terminal_monitor_out on the same clock and that
// threshold_write_in is a pulse from the parameter store


`timescale 1ns/100ps
`default_nettype none

module ssor_routing (
  input  wire logic                          sys_clk_in,
  input  wire logic                          arst_n_in,
  input  wire logic [ssor_pkg::PARAM_W-1:0]  output_alloc_param_a_in,
  input  wire logic [ssor_pkg::PARAM_W-1:0]  output_alloc_param_b_in,
  input  wire logic [ssor_pkg::PARAM_W-1:0]  output_alloc_param_c_in,
  input  wire logic [ssor_pkg::PARAM_W-1:0]  output_alloc_param_d_in,
  input  wire logic [ssor_pkg::SPEED_W-1:0]  rotation_detect_threshold_in,
  input  wire logic                          threshold_write_in,
  input  wire logic [1:0]                    ctrl_mode_in,
  input  wire logic [ssor_pkg::SPEED_W-1:0]  motor_speed_abs_in,
  input  wire logic                          position_done_in,
  input  wire logic                          fault_in,
  input  wire logic                          warning_in,
  input  wire logic                          brake_release_in,
  input  wire logic                          main_power_pin_in,
  input  wire logic                          hw_baseblock_pin_in,
  input  wire logic                          abs_encoder_in,
  input  wire logic                          sensor_on_command_in,
  input  wire logic                          enc_pos_sent_in,
  input  wire logic                          pole_detect_done_in,
  input  wire logic                          servo_on_command_in,
  output logic [ssor_pkg::NUM_TERM-1:0]      io_signal_connector_out,
  output logic [ssor_pkg::NUM_TERM-1:0]      terminal_monitor_out,
  output logic [ssor_pkg::NUM_SIG-1:0]       status_out,
  output logic [ssor_pkg::SPEED_W-1:0]       threshold_out,
  output logic                               drive_stop_out
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [ssor_pkg::NUM_PINS-1:0] pins_raw;
  logic [ssor_pkg::NUM_PINS-1:0] pins_sync;
  logic                          main_power_s;
  logic                          hw_baseblock_s;

  // both pins are slow levels from outside the clock domain; each passes
  // two flops so ready never sees a half-settled level
  assign pins_raw[ssor_pkg::PIN_MAIN] = main_power_pin_in;
  assign pins_raw[ssor_pkg::PIN_HWBB] = hw_baseblock_pin_in;

  ssor_sync2 #(
    .WIDTH (ssor_pkg::NUM_PINS)
  ) u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .arst_n_in  (arst_n_in),
    .async_in   (pins_raw),
    .sync_out   (pins_sync)
  );

  assign main_power_s   = pins_sync[ssor_pkg::PIN_MAIN];
  assign hw_baseblock_s = pins_sync[ssor_pkg::PIN_HWBB];

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  logic [ssor_pkg::SPEED_W-1:0]  thresh_q;
  logic [ssor_pkg::SPEED_W-1:0]  thresh_d;
  logic                          first_sv_seen_q;
  logic                          first_sv_seen_d;
  logic                          enc_sent_q;
  logic                          enc_sent_d;
  logic [ssor_pkg::NUM_SIG-1:0]  status_q;
  logic [ssor_pkg::NUM_SIG-1:0]  status_d;
  logic [ssor_pkg::NUM_TERM-1:0] term_q;
  logic [ssor_pkg::NUM_TERM-1:0] term_d;
  logic [ssor_pkg::NUM_TERM-1:0] mon_q;
  logic [ssor_pkg::NUM_TERM-1:0] mon_d;
  logic                          stop_q;
  logic                          stop_d;

  // ----------------------------------------------------------------
  // allocation fields
  // ----------------------------------------------------------------
  logic [ssor_pkg::DIG_W-1:0] alloc [ssor_pkg::NUM_SIG];
  logic                       brake_invert;

  always_comb begin
    alloc[ssor_pkg::SIG_POS_DONE] =
      output_alloc_param_a_in[ssor_pkg::DIG0_LSB +: ssor_pkg::DIG_W];
    alloc[ssor_pkg::SIG_ROTATION] =
      output_alloc_param_a_in[ssor_pkg::DIG2_LSB +: ssor_pkg::DIG_W];
    alloc[ssor_pkg::SIG_RDY]  =
      output_alloc_param_a_in[ssor_pkg::DIG3_LSB +: ssor_pkg::DIG_W];
    alloc[ssor_pkg::SIG_BRAKE] =
      output_alloc_param_b_in[ssor_pkg::DIG2_LSB +: ssor_pkg::DIG_W];
    alloc[ssor_pkg::SIG_WARN] =
      output_alloc_param_b_in[ssor_pkg::DIG3_LSB +: ssor_pkg::DIG_W];
    alloc[ssor_pkg::SIG_ALARM] =
      output_alloc_param_c_in[ssor_pkg::DIG1_LSB +: ssor_pkg::DIG_W];
  end

  assign brake_invert = output_alloc_param_d_in[ssor_pkg::BRAKE_INV_BIT];

  // a field picks terminal 1..NUM_TERM; zero and values past the last
  // terminal leave the status unrouted
  logic [ssor_pkg::NUM_SIG-1:0] alloc_on;

  for (genvar s = 0; s < ssor_pkg::NUM_SIG; s++) begin : g_alloc
    assign alloc_on[s] = (alloc[s] != '0) &&
                         (alloc[s] <= ssor_pkg::DIG_W'(ssor_pkg::NUM_TERM));
  end

  // ----------------------------------------------------------------
  // threshold register
  // ----------------------------------------------------------------
  // out-of-range writes saturate rather than wrap, so a bad value
  // can never make rotation detection fire at low speed
  always_comb begin
    thresh_d = thresh_q;
    if (threshold_write_in) begin
      if (rotation_detect_threshold_in > ssor_pkg::THRESH_MAX) begin
        thresh_d = ssor_pkg::THRESH_MAX;
      end else begin
        thresh_d = rotation_detect_threshold_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      thresh_q <= ssor_pkg::THRESH_RST;
    end else begin
      thresh_q <= thresh_d;
    end
  end

  // ----------------------------------------------------------------
  // servo ready conditions
  // ----------------------------------------------------------------
  logic power_ok;
  logic unblocked_ok;
  logic healthy_ok;
  logic sensor_ok;
  logic pole_ok;
  logic ready_c;

  always_comb begin
    first_sv_seen_d = first_sv_seen_q | servo_on_command_in;
    // position-data flag follows the sensor-on command; a send in the
    // same cycle as sensor-on is kept
    if (!sensor_on_command_in) begin
      enc_sent_d = 1'b0;
    end else begin
      enc_sent_d = enc_sent_q | enc_pos_sent_in;
    end
    sensor_ok = !abs_encoder_in || (sensor_on_command_in && enc_sent_q);
    // before the first servo-on the pole condition is waived; once it
    // arrives detection runs and ready waits for it to finish
    pole_ok = pole_detect_done_in ||
              (!first_sv_seen_q && !servo_on_command_in);
    power_ok     = main_power_s;
    unblocked_ok = !hw_baseblock_s;
    healthy_ok   = !fault_in;
    ready_c      = power_ok && unblocked_ok && healthy_ok &&
                   sensor_ok && pole_ok;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      first_sv_seen_q <= 1'b0;
      enc_sent_q      <= 1'b0;
    end else begin
      first_sv_seen_q <= first_sv_seen_d;
      enc_sent_q      <= enc_sent_d;
    end
  end

  // ----------------------------------------------------------------
  // status generation
  // ----------------------------------------------------------------
  logic pos_mode_ok;

  // positioning complete is only detected in position control; every
  // other mode, including the unused code, holds it off
  always_comb begin
    case (ssor_pkg::ssor_mode_e'(ctrl_mode_in))
      ssor_pkg::SSOR_MODE_POSITION: pos_mode_ok = 1'b1;
      ssor_pkg::SSOR_MODE_SPEED:    pos_mode_ok = 1'b0;
      ssor_pkg::SSOR_MODE_TORQUE:   pos_mode_ok = 1'b0;
      default:                      pos_mode_ok = 1'b0;
    endcase
  end

  always_comb begin
    status_d = '0;
    status_d[ssor_pkg::SIG_POS_DONE] = position_done_in && pos_mode_ok;
    status_d[ssor_pkg::SIG_ROTATION] = (motor_speed_abs_in > thresh_q);
    status_d[ssor_pkg::SIG_RDY]      = ready_c;
    status_d[ssor_pkg::SIG_BRAKE]    = brake_release_in ^ brake_invert;
    status_d[ssor_pkg::SIG_WARN]     = warning_in;
    status_d[ssor_pkg::SIG_ALARM]    = !fault_in;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  // ----------------------------------------------------------------
  // stop request
  // ----------------------------------------------------------------
  // a warning never reaches the stop request, so operation goes on
  // through it; only an alarm demands the stop
  always_comb begin
    stop_d = fault_in;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stop_q <= 1'b0;
    end else begin
      stop_q <= stop_d;
    end
  end

  // ----------------------------------------------------------------
  // terminal routing
  // ----------------------------------------------------------------
  logic [ssor_pkg::NUM_SIG-1:0] hit  [ssor_pkg::NUM_TERM];
  logic [ssor_pkg::NUM_TERM-1:0] route_c;

  // terminal t answers to field value t+1; value 0 matches no terminal
  for (genvar t = 0; t < ssor_pkg::NUM_TERM; t++) begin : g_term
    for (genvar s = 0; s < ssor_pkg::NUM_SIG; s++) begin : g_sig
      assign hit[t][s] =
        alloc_on[s] && (alloc[s] == ssor_pkg::DIG_W'(t + 1));
    end
    assign route_c[t] = ^(status_q & hit[t]);
  end

  always_comb begin
    term_d = route_c;
  end

  // statuses are registered before routing and terminals after it, so a
  // parameter change moves a status without a combinational glitch
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      term_q <= '0;
    end else begin
      term_q <= term_d;
    end
  end

  // ----------------------------------------------------------------
  // terminal monitor
  // ----------------------------------------------------------------
  // a flop copy of its own, so the monitor path never loads the
  // connector drivers
  always_comb begin
    mon_d = route_c;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mon_q <= '0;
    end else begin
      mon_q <= mon_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the alarm terminal closes while healthy, so a cut line reads as a
  // fault to the outside power interlock
  assign io_signal_connector_out = term_q;
  assign terminal_monitor_out    = mon_q;
  assign status_out              = status_q;
  assign threshold_out           = thresh_q;
  assign drive_stop_out          = stop_q;

endmodule

`default_nettype wire

// [hdl/ssor_pkg.sv]
// package for the servo status output routing block
// holds field positions, widths, reset values and status indexes;
// assumes users refer to every name as ssor_pkg::name

package ssor_pkg;

  // ----------------------------------------------------------------
  // allocation parameter layout
  // ----------------------------------------------------------------
  localparam int unsigned PARAM_W   = 16;
  localparam int unsigned DIG_W     = 4;
  localparam int unsigned DIG0_LSB  = 0;
  localparam int unsigned DIG1_LSB  = 4;
  localparam int unsigned DIG2_LSB  = 8;
  localparam int unsigned DIG3_LSB  = 12;
  localparam int unsigned BRAKE_INV_BIT = 0;

  // ----------------------------------------------------------------
  // terminals and status signals
  // ----------------------------------------------------------------
  localparam int unsigned NUM_TERM = 4;
  localparam int unsigned NUM_SIG  = 6;
  localparam int unsigned SIG_POS_DONE = 0;
  localparam int unsigned SIG_ROTATION = 1;
  localparam int unsigned SIG_RDY      = 2;
  localparam int unsigned SIG_BRAKE    = 3;
  localparam int unsigned SIG_WARN     = 4;
  localparam int unsigned SIG_ALARM    = 5;

  // ----------------------------------------------------------------
  // rotation detection threshold, unit 1 rpm
  // ----------------------------------------------------------------
  localparam int unsigned SPEED_W = 16;
  localparam logic [SPEED_W-1:0] THRESH_MAX = 16'h2710;
  localparam logic [SPEED_W-1:0] THRESH_RST = 16'h0014;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS = 2;
  localparam int unsigned PIN_MAIN = 0;
  localparam int unsigned PIN_HWBB = 1;

  // ----------------------------------------------------------------
  // control modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSOR_MODE_SPEED    = 2'b00,
    SSOR_MODE_POSITION = 2'b01,
    SSOR_MODE_TORQUE   = 2'b10
  } ssor_mode_e;

endpackage

// [hdl/ssor_sync2.sv]
// two flip-flop synchroniser for a group of pin levels
// assumes each bit is a slow level from outside the clock domain

`timescale 1ns/100ps
`default_nettype none

module ssor_sync2 #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             sys_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------
  // first stage feeds only the second stage: it may be metastable
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// [testbench/ssor_tb_pkg.sv]
// shared bench types and the expected terminal routing
// assumes field placement as in ssor_pkg and field values 1..4 for terminals

package ssor_tb_pkg;

  typedef struct {
    logic        is_thr;
    logic [15:0] exp;
  } ssor_note_s;

  function automatic logic [3:0] route_f(input logic [5:0] s, input logic [15:0] a, b, c);
    logic [3:0] f [6];
    logic [3:0] t;
    f = '{a[3:0], a[11:8], a[15:12], b[11:8], b[15:12], c[7:4]};
    t = 4'h0;
    for (int i = 0; i < 6; i++)
      for (int k = 1; k < 5; k++)
        if (f[i] == k) t[k-1] ^= s[i];
    return t;
  endfunction

endpackage

// [testbench/ssor_routing_monitor.sv]
// concurrent checks on the ports of ssor_routing
// assumes one clock, statuses one edge and terminals two edges behind inputs

`timescale 1ns/100ps
`default_nettype none

module ssor_routing_monitor (
  input wire logic        sys_clk_in,
  input wire logic        arst_n_in,
  input wire logic [15:0] output_alloc_param_a_in,
  input wire logic [15:0] output_alloc_param_b_in,
  input wire logic [15:0] output_alloc_param_c_in,
  input wire logic [15:0] output_alloc_param_d_in,
  input wire logic [15:0] rotation_detect_threshold_in,
  input wire logic        threshold_write_in,
  input wire logic [1:0]  ctrl_mode_in,
  input wire logic [15:0] motor_speed_abs_in,
  input wire logic        position_done_in,
  input wire logic        fault_in,
  input wire logic        warning_in,
  input wire logic        brake_release_in,
  input wire logic [3:0]  io_signal_connector_out,
  input wire logic [3:0]  terminal_monitor_out,
  input wire logic [5:0]  status_out,
  input wire logic [15:0] threshold_out,
  input wire logic        drive_stop_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  // ------------
  // pipeline age
  // ------------
  // outputs lag the inputs for a few edges after reset, so checks wait
  logic [2:0] age_q;
  logic [2:0] age_d;
  logic       up;
  logic       inv;
  always_comb age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
    if (!arst_n_in) age_q <= 3'h0;
    else age_q <= age_d;
  assign up = age_q >= 3'h3;
  assign inv = output_alloc_param_d_in[0];

  chk_alarm_level: assert property (up |=> status_out[5] == !$past(fault_in))
    else $error("alarm status does not follow fault");
  chk_stop_fault: assert property (up |=> drive_stop_out == $past(fault_in))
    else $error("stop request does not follow fault");
  chk_posdone_mode: assert property (up |=> status_out[0] ==
    ($past(position_done_in) && $past(ctrl_mode_in) == 2'b01))
    else $error("positioning complete outside position mode");
  chk_warn_level: assert property (up |=> status_out[4] == $past(warning_in))
    else $error("warning status wrong");
  chk_rot_compare: assert property (up |=> status_out[1] ==
    ($past(motor_speed_abs_in) > $past(threshold_out))) else $error("rotation compare wrong");
  chk_fault_ready: assert property (fault_in |=> !status_out[2])
    else $error("ready with fault");
  chk_term_xor: assert property (up |=> io_signal_connector_out == ssor_tb_pkg::route_f(
    $past(status_out), $past(output_alloc_param_a_in), $past(output_alloc_param_b_in),
    $past(output_alloc_param_c_in))) else $error("terminal routing wrong");
  chk_monitor_copy: assert property (terminal_monitor_out == io_signal_connector_out)
    else $error("monitor differs from terminals");
  chk_brake_pol: assert property (up |=> status_out[3] ==
    ($past(brake_release_in) ^ $past(inv))) else $error("brake polarity wrong");
  chk_thresh_sat: assert property (threshold_write_in |=> threshold_out ==
    (($past(rotation_detect_threshold_in) > 16'h2710) ? 16'h2710
    : $past(rotation_detect_threshold_in))) else $error("threshold load wrong");

  cover property (up && fault_in);
  cover property (threshold_write_in);
  cover property ($rose(status_out[2]));
endmodule

bind ssor_routing ssor_routing_monitor ssor_routing_monitor_i (.sys_clk_in, .arst_n_in,
  .output_alloc_param_a_in, .output_alloc_param_b_in, .output_alloc_param_c_in,
  .output_alloc_param_d_in, .rotation_detect_threshold_in, .threshold_write_in,
  .ctrl_mode_in, .motor_speed_abs_in, .position_done_in, .fault_in, .warning_in,
  .brake_release_in, .io_signal_connector_out, .terminal_monitor_out, .status_out,
  .threshold_out, .drive_stop_out);

`default_nettype wire

// [testbench/ssor_host_model.sv]
// host controller and power interlock facing the status outputs
// assumes the statuses of ssor_routing and the same clock

`timescale 1ns/100ps
`default_nettype none

module ssor_host_model (
  input  wire logic       sys_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       host_en_in,
  input  wire logic [3:0] lag_in,
  input  wire logic [5:0] status_in,
  output logic            main_power_pin_out,
  output logic            servo_on_out
);
  logic       armed_q;
  logic [3:0] cnt_q;
  // power is cut only once the alarm line has been seen healthy
  assign main_power_pin_out = !(armed_q && !status_in[5]);
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      armed_q <= 1'b0;
      cnt_q <= 4'h0;
      servo_on_out <= 1'b0;
    end else begin
      armed_q <= armed_q | status_in[5];
      cnt_q <= (host_en_in && status_in[2] && !servo_on_out) ? cnt_q + 4'h1 : 4'h0;
      servo_on_out <= host_en_in && (servo_on_out || (status_in[2] && cnt_q == lag_in));
    end
  end
endmodule

`default_nettype wire

// [testbench/ssor_routing_bench.sv]
// self-checking bench for ssor_routing with a host model
// assumes registered outputs and a two-flop pin path; waits are fixed counts

`timescale 1ns/100ps
`default_nettype none

module ssor_routing_bench;
  logic        clk, rst_n, thr_wr, pdone, flt, wrn, brk, bb, abse, sens, sent, pole;
  logic        host_en, pwr, son, stop;
  logic [15:0] pa, pb, pc, pd, thr, spd, thr_o, thr_e, got;
  logic [1:0]  mode;
  logic [3:0]  lag, term, mon;
  logic [5:0]  stat;
  int          err_count, checked;
  ssor_tb_pkg::ssor_note_s notes[$];
  ssor_tb_pkg::ssor_note_s n;

  ssor_routing ssor_routing_i (.sys_clk_in(clk), .arst_n_in(rst_n),
    .output_alloc_param_a_in(pa), .output_alloc_param_b_in(pb),
    .output_alloc_param_c_in(pc), .output_alloc_param_d_in(pd),
    .rotation_detect_threshold_in(thr), .threshold_write_in(thr_wr), .ctrl_mode_in(mode),
    .motor_speed_abs_in(spd), .position_done_in(pdone), .fault_in(flt), .warning_in(wrn),
    .brake_release_in(brk), .main_power_pin_in(pwr), .hw_baseblock_pin_in(bb),
    .abs_encoder_in(abse), .sensor_on_command_in(sens), .enc_pos_sent_in(sent),
    .pole_detect_done_in(pole), .servo_on_command_in(son), .io_signal_connector_out(term),
    .terminal_monitor_out(mon), .status_out(stat), .threshold_out(thr_o),
    .drive_stop_out(stop));
  ssor_host_model ssor_host_model_i (.sys_clk_in(clk), .arst_n_in(rst_n), .host_en_in(host_en),
    .lag_in(lag), .status_in(stat), .main_power_pin_out(pwr), .servo_on_out(son));

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
  endtask

  // note the expected stop, statuses, monitor and terminals for ready r
  task automatic note(input logic r);
    logic [5:0] s;
    logic [3:0] t;
    s = {!flt, wrn, brk ^ pd[0], r, spd > thr_e, pdone && mode == 2'b01};
    t = ssor_tb_pkg::route_f(s, pa, pb, pc);
    notes.push_back('{1'b0, {1'b0, flt, s, t, t}});
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(negedge clk) begin
    if (notes.size() > 0) begin
      n = notes.pop_front();
      got = n.is_thr ? thr_o : {1'b0, stop, stat, mon, term};
      checked++;
      if (got !== n.exp) begin
        err_count++;
        $display("[FAIL] %s exp %h got %h", n.is_thr ? "threshold" : "outputs", n.exp, got);
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rst_n, thr_wr, pdone, flt, wrn, brk, bb, abse, sens, sent, pole, host_en} = 12'h000;
    {pa, pb, pc, pd, thr, spd} = 96'h0;
    mode = 2'b00;
    lag = 4'h5;
    thr_e = 16'h0014;
    void'($urandom(84));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    settle(8);
    notes.push_back('{1'b1, 16'h0014});
    note(1'b1);
    host_en <= 1'b1;
    settle(16);
    note(1'b0);
    pole <= 1'b1;
    settle(8);
    note(1'b1);
    for (int i = 0; i < 3; i++) begin
      thr <= (i == 0) ? 16'hffff : (i == 1) ? 16'h2710 : 16'h0064;
      thr_wr <= 1'b1;
      @(posedge clk);
      thr_wr <= 1'b0;
      settle(2);
      notes.push_back('{1'b1, (i == 2) ? 16'h0064 : 16'h2710});
    end
    thr_e = 16'h0064;
    pa <= 16'h1000;
    for (int i = 0; i < 6; i++) begin
      abse <= i < 4;
      sens <= i == 1 || i == 2;
      sent <= i == 2;
      bb <= i == 4;
      @(posedge clk);
      sent <= 1'b0;
      settle(8);
      note(i == 2 || i == 5);
    end
    for (int i = 0; i < 40; i++) begin
      pa <= 16'($urandom()) & 16'h7777;
      pb <= 16'($urandom()) & 16'h77ff;
      pc <= 16'($urandom()) & 16'hff7f;
      pd <= 16'($urandom()) & 16'h0001;
      mode <= 2'($urandom_range(2));
      spd <= 16'($urandom_range(200));
      {pdone, flt, wrn, brk} <= 4'($urandom());
      settle(8);
      note(!flt);
    end
    for (int i = 0; i < 20 && notes.size() > 0; i++) @(posedge clk);
    if (notes.size() > 0) err_count++;
    give_verdict();
  end
endmodule

`default_nettype wire
